// ---- bench/ian_cpu_model.sv ----
// Stand-in for the instruction sequencer: one instruction per three clocks
`timescale 1ns/1ps
module ian_cpu_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic busy_i,
	input wire logic [1:0] kind_i,
	output logic done_o,
	output logic hold_o,
	output logic ret_o,
	output logic brk_o
);
	logic [1:0] cnt_q;
	// Stalls while vectoring, since boundaries are ignored then
	always_ff @(posedge clk_i) begin
		if (rst_i)
			cnt_q <= 2'h0;
		else if (!busy_i)
			cnt_q <= done_o ? 2'h0 : cnt_q + 2'h1;
	end
	assign done_o = cnt_q == 2'h2 && !busy_i;
	assign hold_o = done_o && kind_i == 2'h1;
	assign ret_o = done_o && kind_i == 2'h2;
	assign brk_o = done_o && kind_i == 2'h3;
endmodule

// ---- bench/ian_top_monitor.sv ----
// Port assertions for the acknowledge logic
`timescale 1ns/1ps
module ian_top_monitor (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic accept_enable_flag_o,
	input wire logic busy_o,
	input wire logic push_o,
	input wire logic pc_load_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence pushes_s;
		push_o[*3] ##1 pc_load_o;
	endsequence
	chk_bus_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	chk_push_order: assert property ($rose(push_o) |-> pushes_s)
		else $error("push sequence broken");
	chk_busy_min: assert property ($rose(busy_o) |-> busy_o[*6])
		else $error("vectoring too quick");
	chk_vector_time: assert property ($rose(busy_o) |-> ##[6:7] pc_load_o)
		else $error("vector load late");
	chk_enable_drop: assert property (pc_load_o |-> !accept_enable_flag_o)
		else $error("enable kept at vector load");
	chk_push_busy: assert property (push_o |-> busy_o)
		else $error("push outside vectoring");
	chk_busy_end: assert property ($fell(busy_o) |-> pc_load_o)
		else $error("busy ended without vector");
endmodule

// ---- bench/testbench.sv ----
// Self-checking bench for the acknowledge and nesting logic
`timescale 1ns/1ps
module testbench;
	import ian_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [15:0] src = 16'h0;
	logic [1:0] kind = 2'h0;
	logic ae_set = 1'b0;
	logic pl = 1'b0;
	logic [7:0] processor_status_byte = 8'h00;
	logic [31:0] rdat;
	logic ack, aef, busy, push, pcl, done, hold, ret, break_trap_instr;
	logic [15:0] vec;
	logic [31:0] rq[$];
	logic [15:0] vq[$];
	logic [7:0] pq[$];
	logic [7:0] pdat;
	logic in_service_level_flag;
	int errors = 0;
	int tests_run = 0;
	int s;
	int t;
	always #25 clk_i = ~clk_i;
	ian_top i_ian_top (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
		.wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(rdat),
		.wb_ack_o(ack), .src_req_i(src), .pc_i(16'h1234), .instr_done_i(done),
		.instr_hold_i(hold), .instr_ret_i(ret), .instr_brk_i(break_trap_instr), .ae_set_i(ae_set && done),
		.ae_clr_i(1'b0), .psw_load_i(pl && done), .psw_data_i(processor_status_byte), .accept_enable_flag_o(aef),
		.in_service_level_flag_o(in_service_level_flag), .busy_o(busy), .push_o(push), .push_data_o(pdat),
		.pc_load_o(pcl), .vec_addr_o(vec));
	ian_cpu_model i_ian_cpu_model (.clk_i(clk_i), .rst_i(rst_i), .busy_i(busy),
		.kind_i(kind), .done_o(done), .hold_o(hold), .ret_o(ret), .brk_o(break_trap_instr));
	task report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task cmp_rd(input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("mismatch t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task cmp_byte(input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("mismatch t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// Pushed bytes in order, then the flags expected right after the vector load
	task note(input logic [15:0] v, input logic [7:0] p, input logic i);
		vq.push_back(v);
		pq.push_back(p);
		pq.push_back(8'h12);
		pq.push_back(8'h34);
		pq.push_back({7'h00, i});
	endtask
	task cmp_vec(input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("mismatch t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// Results are judged here, against notes left by the drivers; notes left over at the end count as errors
	always @(posedge clk_i) begin
		if (ack === 1'b1 && !we)
			cmp_rd(rq.pop_front(), rdat);
		if (push === 1'b1)
			cmp_byte(pq.pop_front(), pdat);
		if (pcl === 1'b1) begin
			cmp_vec(vq.pop_front(), vec);
			cmp_byte(pq.pop_front(), {6'h00, aef, in_service_level_flag});
		end
	end
	task wt(input logic on_bus);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while ((on_bus ? ack : done) !== 1'b1 && n < 60);
		if (n >= 60) begin
			errors++;
			report_and_stop();
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		wt(1'b1);
		cyc <= 1'b0;
		@(posedge clk_i);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		wb(1'b0, a, 32'h0);
	endtask
	// Kind 1 is the enable instruction, 2 a return that reloads the status byte
	task ins(input logic [1:0] k, input logic [7:0] p);
		kind <= k;
		pl <= k == 2'h2;
		processor_status_byte <= p;
		ae_set <= k == 2'h1;
		wt(1'b0);
		kind <= 2'h0;
		pl <= 1'b0;
		ae_set <= 1'b0;
		@(posedge clk_i);
	endtask
	task pulse(input logic [15:0] m);
		src <= m;
		@(posedge clk_i);
		src <= 16'h0;
	endtask
	initial begin
		s = $urandom(34);
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(ADR_STAT, 32'h2);
		rd(ADR_MASK, 32'hFFFF);
		rd(ADR_PRIO, 32'hFFFF);
		rd(8'h10, 32'h0);
		$display("reset values done");
		note(BRK_VEC, 8'h02, 1'b1);
		ins(2'h3, 8'h00);
		repeat (3) ins(2'h0, 8'h00);
		rd(ADR_STAT, 32'h2);
		$display("break done");
		s = $urandom % 16;
		t = (s + 1 + $urandom % 15) % 16;
		pulse(16'h1 << s);
		repeat (3) ins(2'h0, 8'h00);
		wb(1'b1, ADR_PRIO, ~(32'h1 << s));
		wb(1'b1, ADR_MASK, ~(32'h1 << s));
		note(VEC_BASE_DEF + 16'(2 * s), 8'h82, 1'b0);
		ins(2'h1, 8'h80);
		repeat (3) ins(2'h0, 8'h00);
		rd(ADR_STAT, 32'h0);
		$display("maskable done");
		wb(1'b1, ADR_MASK, ~((32'h1 << s) | (32'h1 << t)));
		pulse(16'h1 << t);
		ins(2'h1, 8'h80);
		repeat (3) ins(2'h0, 8'h00);
		note(VEC_BASE_DEF + 16'(2 * t), 8'h82, 1'b1);
		ins(2'h2, 8'h82);
		repeat (3) ins(2'h0, 8'h00);
		rd(ADR_STAT, 32'h2);
		$display("nesting done");
		wb(1'b1, ADR_PRIO, ~(32'h1 << (s > t ? s : t)));
		pulse((16'h1 << s) | (16'h1 << t));
		note(VEC_BASE_DEF + 16'(2 * (s > t ? s : t)), 8'h82, 1'b0);
		note(VEC_BASE_DEF + 16'(2 * (s > t ? t : s)), 8'h82, 1'b1);
		ins(2'h1, 8'h80);
		repeat (3) ins(2'h0, 8'h00);
		ins(2'h2, 8'h82);
		repeat (3) ins(2'h0, 8'h00);
		if (vq.size() != 0 || rq.size() != 0 || pq.size() != 0)
			errors++;
		$display("priority done");
		report_and_stop();
	end
endmodule
bind ian_top ian_top_monitor i_ian_top_monitor (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.accept_enable_flag_o(accept_enable_flag_o), .busy_o(busy_o), .push_o(push_o),
	.pc_load_o(pc_load_o));

// ---- hdl/ian_pkg.sv ----
// Constants and types shared by the interrupt acknowledge and nesting logic
package ian_pkg;
	localparam int ADR_W = 8;
	localparam logic [7:0] ADR_REQ = 8'h00;
	localparam logic [7:0] ADR_MASK = 8'h04;
	localparam logic [7:0] ADR_PRIO = 8'h08;
	localparam logic [7:0] ADR_STAT = 8'h0C;
	localparam int STAT_IE_BIT = 0;
	localparam int STAT_ISP_BIT = 1;
	localparam int STAT_BUSY_BIT = 2;
	localparam int PSW_IE_BIT = 7;
	localparam int PSW_ISP_BIT = 1;
	localparam logic [7:0] PSW_RST = 8'h02;
	localparam logic [15:0] BRK_VEC = 16'h003E;
	localparam logic [15:0] VEC_BASE_DEF = 16'h0004;
	// Latency in CPU clocks from request to vector load, at the earliest boundary
	localparam int LAT_MIN_HI = 7;
	localparam int LAT_MIN_LO = 8;
	// Fixed cost: decision cycle, three pushes, vector load
	localparam int SEQ_FIXED = 5;
	localparam logic [1:0] DLY_HI = 2'(LAT_MIN_HI - SEQ_FIXED);
	localparam logic [1:0] DLY_LO = 2'(LAT_MIN_LO - SEQ_FIXED);
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_DLY = 6'h02,
		ST_PPSW = 6'h04,
		ST_PPCH = 6'h08,
		ST_PPCL = 6'h10,
		ST_VEC = 6'h20
	} ian_state_e;
endpackage

// ---- hdl/ian_top.sv ----
// Interrupt acknowledge, arbitration and nesting control with Wishbone flag registers
`timescale 1ns/1ps
module ian_top #(
	parameter int N_SRC = 16,
	parameter int IDX_W = 4,
	// Entry k names the source of default rank k, rank 0 winning
	parameter logic [N_SRC*IDX_W-1:0] ORDER = 64'hFEDCBA9876543210,
	parameter logic [15:0] VEC_BASE = ian_pkg::VEC_BASE_DEF
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [ian_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [N_SRC-1:0] src_req_i,
	input wire logic [15:0] pc_i,
	input wire logic instr_done_i,
	input wire logic instr_hold_i,
	input wire logic instr_ret_i,
	input wire logic instr_brk_i,
	input wire logic ae_set_i,
	input wire logic ae_clr_i,
	input wire logic psw_load_i,
	input wire logic [7:0] psw_data_i,
	output logic accept_enable_flag_o,
	output logic in_service_level_flag_o,
	output logic busy_o,
	output logic push_o,
	output logic [7:0] push_data_o,
	output logic pc_load_o,
	output logic [15:0] vec_addr_o
);
	import ian_pkg::*;

	typedef struct packed {
		ian_state_e st;
		logic [1:0] cnt;
		logic [N_SRC-1:0] req;
		logic [N_SRC-1:0] mask;
		logic [N_SRC-1:0] prio;
		logic ie;
		logic in_service_level_flag;
		logic defer;
		logic wr_hold;
		logic brk_pend;
		logic is_brk;
		logic [IDX_W-1:0] win;
		logic win_pr;
		logic [15:0] pc;
		logic busy;
		logic push;
		logic [7:0] push_data;
		logic pc_load;
		logic [15:0] vec;
		logic ack;
		logic [31:0] dat;
	} ian_state_s;

	ian_state_s s_q;
	ian_state_s s_d;

	logic [N_SRC-1:0] cand;
	logic found;
	logic [IDX_W-1:0] pick;
	logic pick_pr;
	logic wb_go;
	logic flag_wr;
	logic [31:0] wmask;
	logic [31:0] req_w;
	logic [31:0] mask_w;
	logic [31:0] prio_w;
	logic [7:0] psw_now;

	// Byte lanes for writes
	for (genvar b = 0; b < 4; b++) begin : g_sel
		assign wmask[b*8 +: 8] = {8{wb_sel_i[b]}};
	end

	assign req_w = 32'(s_q.req);
	assign mask_w = 32'(s_q.mask);
	assign prio_w = 32'(s_q.prio);

	always_comb begin
		psw_now = PSW_RST;
		psw_now[PSW_IE_BIT] = s_q.ie;
		psw_now[PSW_ISP_BIT] = s_q.in_service_level_flag;
	end

	// High-priority servicing admits only priority-0 candidates
	assign cand = s_q.req & ~s_q.mask & (s_q.in_service_level_flag ? {N_SRC{1'b1}} : ~s_q.prio);

	// Two passes over the fixed order: priority 1 first, then priority 0, which overrides it
	always_comb begin
		logic [IDX_W-1:0] idx;
		idx = '0;
		found = 1'b0;
		pick = '0;
		pick_pr = 1'b0;
		for (int k = N_SRC - 1; k >= 0; k--) begin
			idx = ORDER[k*IDX_W +: IDX_W];
			if (cand[idx] && s_q.prio[idx]) begin
				found = 1'b1;
				pick = idx;
				pick_pr = 1'b1;
			end
		end
		for (int k = N_SRC - 1; k >= 0; k--) begin
			idx = ORDER[k*IDX_W +: IDX_W];
			if (cand[idx] && !s_q.prio[idx]) begin
				found = 1'b1;
				pick = idx;
				pick_pr = 1'b0;
			end
		end
	end

	assign wb_go = wb_cyc_i && wb_stb_i && !s_q.ack;
	// A flag write in the boundary cycle itself must still count as a hold
	assign flag_wr = wb_go && wb_we_i
			&& (wb_adr_i == ADR_REQ || wb_adr_i == ADR_MASK || wb_adr_i == ADR_PRIO);

	always_comb begin
		s_d = s_q;
		s_d.push = 1'b0;
		s_d.pc_load = 1'b0;
		s_d.ack = wb_go;
		s_d.dat = '0;

		// Bus side: flag registers
		if (wb_go && wb_we_i) begin
			if (wb_adr_i == ADR_REQ) begin
				s_d.req = N_SRC'((req_w & ~wmask) | (wb_dat_i & wmask));
				s_d.wr_hold = 1'b1;
			end else if (wb_adr_i == ADR_MASK) begin
				s_d.mask = N_SRC'((mask_w & ~wmask) | (wb_dat_i & wmask));
				s_d.wr_hold = 1'b1;
			end else if (wb_adr_i == ADR_PRIO) begin
				s_d.prio = N_SRC'((prio_w & ~wmask) | (wb_dat_i & wmask));
				s_d.wr_hold = 1'b1;
			end
		end else if (wb_go) begin
			if (wb_adr_i == ADR_REQ) begin
				s_d.dat = req_w;
			end else if (wb_adr_i == ADR_MASK) begin
				s_d.dat = mask_w;
			end else if (wb_adr_i == ADR_PRIO) begin
				s_d.dat = prio_w;
			end else if (wb_adr_i == ADR_STAT) begin
				s_d.dat[STAT_IE_BIT] = s_q.ie;
				s_d.dat[STAT_ISP_BIT] = s_q.in_service_level_flag;
				s_d.dat[STAT_BUSY_BIT] = s_q.busy;
			end
		end

		// Status byte changes by instructions
		if (psw_load_i) begin
			s_d.ie = psw_data_i[PSW_IE_BIT];
			s_d.in_service_level_flag = psw_data_i[PSW_ISP_BIT];
		end
		if (ae_set_i) begin
			s_d.ie = 1'b1;
		end
		if (ae_clr_i) begin
			s_d.ie = 1'b0;
		end

		// Break seen while busy is kept, never dropped
		if (instr_brk_i) begin
			s_d.brk_pend = 1'b1;
		end

		// Hold and return instructions block their own boundary and the next one
		if (instr_done_i) begin
			s_d.defer = instr_hold_i || instr_ret_i || s_q.wr_hold || flag_wr;
			s_d.wr_hold = 1'b0;
		end

		case (s_q.st)
			ST_IDLE: begin
				if (instr_done_i && (instr_brk_i || s_q.brk_pend)) begin
					// Break is no hold instruction and ignores every flag
					s_d.brk_pend = 1'b0;
					s_d.is_brk = 1'b1;
					s_d.pc = pc_i;
					s_d.cnt = DLY_HI;
					s_d.busy = 1'b1;
					s_d.st = ST_DLY;
				// Only boundaries are taken, so a long divide stretches the latency
				end else if (instr_done_i && s_q.ie && found && !s_q.defer && !flag_wr
						&& !s_q.wr_hold && !instr_hold_i && !instr_ret_i) begin
					s_d.is_brk = 1'b0;
					s_d.win = pick;
					s_d.win_pr = pick_pr;
					s_d.pc = pc_i;
					s_d.cnt = pick_pr ? DLY_LO : DLY_HI;
					s_d.busy = 1'b1;
					s_d.st = ST_DLY;
				end
			end
			ST_DLY: begin
				s_d.cnt = s_q.cnt - 2'd1;
				if (s_q.cnt == 2'd1) begin
					s_d.st = ST_PPSW;
				end
			end
			ST_PPSW: begin
				s_d.push = 1'b1;
				s_d.push_data = psw_now;
				s_d.st = ST_PPCH;
			end
			ST_PPCH: begin
				s_d.push = 1'b1;
				s_d.push_data = s_q.pc[15:8];
				s_d.st = ST_PPCL;
			end
			ST_PPCL: begin
				s_d.push = 1'b1;
				s_d.push_data = s_q.pc[7:0];
				s_d.st = ST_VEC;
			end
			ST_VEC: begin
				s_d.pc_load = 1'b1;
				s_d.ie = 1'b0;
				if (s_q.is_brk) begin
					s_d.vec = BRK_VEC;
				end else begin
					s_d.vec = VEC_BASE + {11'h000, s_q.win, 1'b0};
					s_d.in_service_level_flag = s_q.win_pr;
					s_d.req[s_q.win] = 1'b0;
				end
				s_d.busy = 1'b0;
				s_d.st = ST_IDLE;
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase

		// Sources set flags last, so a set beats any clear in the same cycle
		s_d.req = s_d.req | src_req_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
			s_q.st <= ST_IDLE;
			s_q.mask <= '1;
			s_q.prio <= '1;
			s_q.in_service_level_flag <= PSW_RST[PSW_ISP_BIT];
			s_q.ie <= PSW_RST[PSW_IE_BIT];
		end else begin
			s_q <= s_d;
		end
	end

	assign wb_dat_o = s_q.dat;
	assign wb_ack_o = s_q.ack;
	assign accept_enable_flag_o = s_q.ie;
	assign in_service_level_flag_o = s_q.in_service_level_flag;
	assign busy_o = s_q.busy;
	assign push_o = s_q.push;
	assign push_data_o = s_q.push_data;
	assign pc_load_o = s_q.pc_load;
	assign vec_addr_o = s_q.vec;
endmodule
